// ### src/serial_port_spi_master.v
// serial port as spi master in clock-stop mode: select, bit clock, data
// assumes inputs are synchronous to clk_sys and config is steady per word
`timescale 1ns/1ns
`include "spi_clkstop_map.vh"

//
// Contract
// [RL1] period is (1 + divide) times 2 system cycles
// [RL2] low phase half, or divide/2 units if even
// [RL3] high phase half, or divide/2+1 units if even
// [RL4] frame sync inverted into active-low select
// [RL5] software sets master source modes 1,1,0,0
// [RL6] select low before first enabling clock edge
// [RL7] mode 11b pol0: first rise one period after
// [RL8] mode 11b pol0: select ends low-phase after fall
// [RL9] sample on rise: 11b pol0, 10b pol1
// [RL10] mode 11b pol1: sample on falling edge
// [RL11] launch on falling edge in three configurations
// [RL12] mode 10b pol1: first fall after high phase
// [RL13] pol1 select end: 10b period, 11b high-phase
// [RL14] mode 11b: first bit half period after select
// [RL15] data output released after last bit closes
// [RL16] mode 10b pol0: launch rise, sample fall
// [RL17] clock toggles only during words, idles at polarity
// [RL18] one bit out and in per period
module serial_port_spi_master #(
    parameter WORD_W = 8,
    parameter DIV_W = 8
) (
    input wire clk_sys,
    input wire reset,
    input wire [1:0] clock_halt_mode,
    input wire tx_clock_polarity,
    input wire [DIV_W-1:0] bit_clock_divider,
    input wire tx_sync_polarity,
    input wire rx_sync_polarity,
    input wire tx_clock_source_mode,
    input wire tx_sync_source_mode,
    input wire rx_clock_source_mode,
    input wire rx_sync_source_mode,
    input wire [WORD_W-1:0] tx_word,
    input wire tx_valid,
    output wire tx_ready,
    output reg [WORD_W-1:0] rx_word,
    output reg rx_valid,
    output reg busy,
    output reg tx_bit_clock,
    output wire tx_frame_sync,
    output wire serial_data_out,
    output reg serial_data_out_oe,
    input wire serial_data_in
);
    localparam LEN_W = DIV_W + 1;
    localparam CNT_W = 8;

    // ============================================================
    // phase lengths in clk_sys cycles; one unit of 2P is two cycles
    function [LEN_W-1:0] phase_len;
        input [DIV_W-1:0] div;
        input high;
        begin
            if (div[0] || div == {DIV_W{1'b0}}) begin
                phase_len = {1'b0, div} + {{(LEN_W-1){1'b0}}, 1'b1}; // [RL2] [RL3]
            end else if (high) begin
                phase_len = {1'b0, div} + {{(LEN_W-2){1'b0}}, 2'h2}; // [RL3]
            end else begin
                phase_len = {1'b0, div}; // [RL2]
            end
        end
    endfunction

    reg [2:0] state_ff;
    reg frame_act_ff;
    reg data_ff;
    reg [WORD_W-1:0] tx_sh_ff;
    reg [CNT_W-1:0] sent_ff;
    reg [CNT_W-1:0] cyc_ff;
    reg pend_ff;
    reg mode_early_ff;
    reg pol_ff;
    reg [DIV_W-1:0] div_ff;
    reg load;
    reg [LEN_W-1:0] load_len;
    wire phase_done;
    wire cfg_ok;
    wire [LEN_W-1:0] idle_len;
    wire [LEN_W-1:0] act_len;
    wire samp_rise;
    wire launch_rise;

    // the block only runs when software set up master clock-stop use;
    // anything else stalls the word source rather than misdrive pins
    assign cfg_ok = clock_halt_mode[`HALT_MODE_ON_BIT] &&
        tx_clock_source_mode && tx_sync_source_mode &&
        !rx_clock_source_mode && !rx_sync_source_mode && // [RL5]
        tx_sync_polarity && rx_sync_polarity; // [RL4]
    assign tx_ready = (state_ff == `ST_IDLE) && cfg_ok;
    assign tx_frame_sync = frame_act_ff ^ tx_sync_polarity; // [RL4]
    assign serial_data_out = data_ff;

    // idle-level phase and the opposite phase of the bit clock
    assign idle_len = phase_len(div_ff, pol_ff);
    assign act_len = phase_len(div_ff, !pol_ff);
    assign samp_rise = mode_early_ff ? !pol_ff : pol_ff; // [RL9] [RL10] [RL16]
    assign launch_rise = !mode_early_ff && !pol_ff; // [RL11] [RL16]

    clock_halt_divider #(
        .LEN_W(LEN_W)
    ) u_div (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(load),
        .len(load_len),
        .phase_done(phase_done)
    );

    // ============================================================
    // divider reload requests
    always @* begin
        load = 1'b0;
        load_len = idle_len;
        case (state_ff)
            `ST_IDLE: begin
                if (tx_valid && cfg_ok) begin
                    load = 1'b1;
                    if (clock_halt_mode == `HALT_MODE_EARLY) begin
                        load_len = phase_len(bit_clock_divider,
                            !tx_clock_polarity); // [RL14]
                    end else begin
                        load_len = phase_len(bit_clock_divider,
                            tx_clock_polarity); // [RL12]
                    end
                end
            end
            `ST_PRE: begin
                load = phase_done; // [RL7]
            end
            `ST_LEAD: begin
                load = phase_done;
                load_len = act_len; // [RL1]
            end
            `ST_TRAIL: begin
                load = phase_done;
            end
            `ST_POST1: begin
                load = phase_done && !mode_early_ff;
                load_len = act_len; // [RL13]
            end
            default: begin
                load = 1'b0;
            end
        endcase
    end

    // ============================================================
    // sequencer
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= `ST_IDLE;
            frame_act_ff <= `SELECT_IDLE_FF;
            data_ff <= `DATA_OUT_RST;
            serial_data_out_oe <= 1'b0;
            tx_bit_clock <= 1'b0;
            tx_sh_ff <= {WORD_W{1'b0}};
            rx_word <= {WORD_W{1'b0}};
            rx_valid <= 1'b0;
            busy <= 1'b0;
            sent_ff <= {CNT_W{1'b0}};
            cyc_ff <= {CNT_W{1'b0}};
            pend_ff <= 1'b0;
            mode_early_ff <= 1'b0;
            pol_ff <= 1'b0;
            div_ff <= {DIV_W{1'b0}};
        end else begin
            rx_valid <= 1'b0;
            case (state_ff)
                `ST_IDLE: begin
                    tx_bit_clock <= tx_clock_polarity; // [RL17]
                    if (tx_valid && cfg_ok) begin
                        mode_early_ff <= (clock_halt_mode == `HALT_MODE_EARLY);
                        pol_ff <= tx_clock_polarity;
                        div_ff <= bit_clock_divider;
                        frame_act_ff <= 1'b1; // [RL6]
                        busy <= 1'b1;
                        sent_ff <= {CNT_W{1'b0}};
                        cyc_ff <= {CNT_W{1'b0}};
                        pend_ff <= 1'b0;
                        tx_sh_ff <= tx_word;
                        if (clock_halt_mode == `HALT_MODE_EARLY) begin
                            state_ff <= `ST_PRE; // [RL14]
                        end else begin
                            data_ff <= tx_word[WORD_W-1];
                            serial_data_out_oe <= 1'b1;
                            tx_sh_ff <= {tx_word[WORD_W-2:0], 1'b0};
                            sent_ff <= {{(CNT_W-1){1'b0}}, 1'b1};
                            state_ff <= `ST_LEAD;
                        end
                    end
                end
                `ST_PRE: begin
                    if (phase_done) begin
                        data_ff <= tx_sh_ff[WORD_W-1]; // [RL14]
                        serial_data_out_oe <= 1'b1;
                        tx_sh_ff <= {tx_sh_ff[WORD_W-2:0], 1'b0};
                        sent_ff <= {{(CNT_W-1){1'b0}}, 1'b1};
                        state_ff <= `ST_LEAD; // [RL7]
                    end
                end
                `ST_LEAD, `ST_TRAIL: begin
                    if (phase_done) begin
                        // edge happens now; new level is !tx_bit_clock
                        tx_bit_clock <= !tx_bit_clock; // [RL17]
                        if (samp_rise == !tx_bit_clock) begin
                            rx_word <= {rx_word[WORD_W-2:0],
                                serial_data_in}; // [RL18]
                        end
                        // sample and launch may share an edge in 11b pol1
                        if (launch_rise == !tx_bit_clock &&
                            (pend_ff || samp_rise == !tx_bit_clock) &&
                            sent_ff < WORD_W[CNT_W-1:0]) begin
                            data_ff <= tx_sh_ff[WORD_W-1]; // [RL11] [RL18]
                            tx_sh_ff <= {tx_sh_ff[WORD_W-2:0], 1'b0};
                            sent_ff <= sent_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                            pend_ff <= 1'b0;
                        end else if (samp_rise == !tx_bit_clock) begin
                            pend_ff <= 1'b1;
                        end
                        if (state_ff == `ST_LEAD) begin
                            state_ff <= `ST_TRAIL;
                        end else if (cyc_ff ==
                            WORD_W[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                            if (mode_early_ff) begin
                                serial_data_out_oe <= 1'b0; // [RL15]
                            end
                            state_ff <= `ST_POST1;
                        end else begin
                            cyc_ff <= cyc_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                            state_ff <= `ST_LEAD;
                        end
                    end
                end
                `ST_POST1: begin
                    if (phase_done) begin
                        serial_data_out_oe <= 1'b0; // [RL15]
                        if (mode_early_ff) begin
                            frame_act_ff <= 1'b0; // [RL8] [RL13]
                            busy <= 1'b0;
                            rx_valid <= 1'b1;
                            state_ff <= `ST_IDLE;
                        end else begin
                            state_ff <= `ST_POST2;
                        end
                    end
                end
                `ST_POST2: begin
                    if (phase_done) begin
                        frame_act_ff <= 1'b0; // [RL13]
                        busy <= 1'b0;
                        rx_valid <= 1'b1;
                        state_ff <= `ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= `ST_IDLE;
                end
            endcase
        end
    end
endmodule // serial_port_spi_master

// ### shared/spi_clkstop_map.vh
// constants for the clock-stop spi master of the serial port
// assumes inclusion by bare name from the design files
`ifndef SPI_CLKSTOP_MAP_VH
`define SPI_CLKSTOP_MAP_VH

// ============================================================
// clock halt mode encodings
`define HALT_MODE_LATE  2'h2
`define HALT_MODE_EARLY 2'h3
`define HALT_MODE_ON_BIT 1

// ============================================================
// reset values
`define SELECT_IDLE_FF 1'h0
`define DATA_OUT_RST 1'h0

// ============================================================
// sequencer states
`define ST_IDLE 3'h0
`define ST_PRE 3'h1
`define ST_LEAD 3'h2
`define ST_TRAIL 3'h3
`define ST_POST1 3'h4
`define ST_POST2 3'h5

`endif

// ### src/clock_halt_divider.v
// phase timer for the bit clock: pulses once a loaded length has run out
// assumes load is a one-cycle pulse and len is at least one
`timescale 1ns/1ns
module clock_halt_divider #(
    parameter LEN_W = 9
) (
    input wire clk_sys,
    input wire reset,
    input wire load,
    input wire [LEN_W-1:0] len,
    output wire phase_done
);
    reg [LEN_W-1:0] cnt_ff;
    reg [LEN_W-1:0] nxt_cnt;

    // ============================================================
    // countdown
    always @* begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = len;
        end else if (cnt_ff != {LEN_W{1'b0}}) begin
            nxt_cnt = cnt_ff - {{(LEN_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_ff <= {LEN_W{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // one-cycle enable when the phase has lasted len cycles; it must not
    // depend on load, since the sequencer derives load from this enable
    assign phase_done = (cnt_ff == {{(LEN_W-1){1'b0}}, 1'b1});
endmodule // clock_halt_divider

// ### dv/spi_master_checker.sv
// assertions on the ports of the clock-stop spi master
// assumes binding onto serial_port_spi_master, one clock domain
`timescale 1ns/1ns
module spi_master_checker (
    input wire clk_sys,
    input wire reset,
    input wire tx_clock_polarity,
    input wire tx_sync_polarity,
    input wire tx_valid,
    input wire tx_ready,
    input wire rx_valid,
    input wire busy,
    input wire tx_bit_clock,
    input wire tx_frame_sync,
    input wire serial_data_out,
    input wire serial_data_out_oe
);
    // ============================================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    clk_idle_a: assert property (
        !busy && !$past(busy) && !$past(reset) &&
        $past(tx_clock_polarity, 2) == tx_clock_polarity |->
        tx_bit_clock == tx_clock_polarity)
        else $error("clock not idle");
    sel_inv_a: assert property (
        tx_frame_sync == (busy ^ tx_sync_polarity))
        else $error("select level");
    oe_busy_a: assert property (
        serial_data_out_oe |-> busy)
        else $error("oe outside word");
    ready_idle_a: assert property (
        tx_ready |-> !busy)
        else $error("ready while busy");
    take_sel_a: assert property (
        tx_valid && tx_ready |=> busy && !tx_ready)
        else $error("take missed");
    end_pulse_a: assert property (
        rx_valid |-> $fell(busy) ##1 !rx_valid)
        else $error("end pulse");
    clk_word_a: assert property (
        $changed(tx_bit_clock) && !$past(reset) &&
        $past(tx_clock_polarity, 2) == tx_clock_polarity |->
        busy || $past(busy))
        else $error("stray clock edge");
    data_edge_a: assert property (
        $changed(serial_data_out) && serial_data_out_oe &&
        $past(serial_data_out_oe) |-> $changed(tx_bit_clock))
        else $error("data off edge");
endmodule // spi_master_checker

bind serial_port_spi_master spi_master_checker u_chk (.clk_sys(clk_sys),
    .reset(reset), .tx_clock_polarity(tx_clock_polarity),
    .tx_sync_polarity(tx_sync_polarity), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .busy(busy),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe));

// ### dv/spi_slave_model.sv
// behavioural spi slave on the far side of the master
// assumes active-low select and a bench-given sampling edge
`timescale 1ns/1ns
module spi_slave_model (
    input wire sel_n,
    input wire sclk,
    input wire mosi,
    input wire sample_rise,
    input wire [7:0] word_in,
    output reg miso,
    output reg [7:0] got
);
    reg [7:0] sh;
    reg seen;
    wire mosi_d;
    // delayed copy: a launch on the sampling edge must not race it
    assign #1 mosi_d = mosi;
    initial miso = 1'h1;
    always @(negedge sel_n) begin
        sh = word_in;
        seen = 0;
        #1 miso = sh[7];
    end
    // released line shows the inverse, never the stale bit
    always @(posedge sel_n) #1 miso = ~miso;
    always @(sclk) if (!sel_n) begin
        if (sclk == sample_rise) begin
            got = {got[6:0], mosi_d};
            seen = 1;
        end else if (seen) begin
            sh = sh << 1;
            #1 miso = sh[7];
        end
    end
endmodule // spi_slave_model

// ### dv/test_serial_port_spi_master.sv
// self-checking bench for the clock-stop spi master
// assumes the slave model and the bound checker
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_serial_port_spi_master;
    reg clk_sys = 0, reset = 1, pol = 0, tvs = 1, rcs = 0, tx_valid = 0;
    reg [1:0] mode = 2'h3;
    reg [7:0] div = 8'h00, tx_word = 8'h00, sl_word = 8'h00;
    wire tx_ready, rx_valid, busy, sclk, sel_n, mosi, oe, miso, srise;
    wire [7:0] rx_word, got;
    integer num_errors = 0, checks_done = 0, cyc = 0, t_sel = 0, t_last = 0;
    integer nedge = 0, efirst = 0, eh = 0, el = 0, n, c, k;
    reg first = 0;
    assign srise = (mode == 2'h3 && !pol) || (mode == 2'h2 && pol);
    serial_port_spi_master u_dut (.clk_sys(clk_sys), .reset(reset),
        .clock_halt_mode(mode), .tx_clock_polarity(pol),
        .bit_clock_divider(div), .tx_sync_polarity(tvs),
        .rx_sync_polarity(tvs), .tx_clock_source_mode(tvs),
        .tx_sync_source_mode(tvs), .rx_clock_source_mode(rcs),
        .rx_sync_source_mode(rcs), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
        .busy(busy), .tx_bit_clock(sclk), .tx_frame_sync(sel_n),
        .serial_data_out(mosi), .serial_data_out_oe(oe),
        .serial_data_in(miso));
    spi_slave_model u_slv (.sel_n(sel_n), .sclk(sclk), .mosi(mosi),
        .sample_rise(srise), .word_in(sl_word), .miso(miso), .got(got));
    // ============================================================
    // clock, phase monitor
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc = cyc + 1;
    always @(negedge sel_n) begin
        t_sel = cyc;
        first = 1;
        nedge = 0;
    end
    always @(sclk) if (!sel_n && !reset) begin
        if (first) `CHK(cyc - t_sel, efirst)
        else `CHK(cyc - t_last, sclk ? el : eh)
        t_last = cyc;
        first = 0;
        if (sclk == srise) nedge = nedge + 1;
    end
    function integer ph_len(input integer d, input integer hi);
        ph_len = (d % 2 == 1 || d == 0) ? d + 1 : (hi ? d + 2 : d);
    endfunction
    // ============================================================
    // tasks
    task report_and_stop;
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task xfer(input [1:0] m, input p, input integer d);
        @(negedge clk_sys);
        mode = m;
        pol = p;
        div = d[7:0];
        eh = ph_len(d, 1);
        el = ph_len(d, 0);
        efirst = m[0] ? eh + el : (p ? eh : el);
        tx_word = $urandom;
        sl_word = $urandom;
        // idle clock settles to the new polarity before the take edge
        @(negedge clk_sys) tx_valid = 1;
        k = 0;
        while (tx_ready !== 1'b1 && k < 50) begin
            @(negedge clk_sys);
            k = k + 1;
        end
        if (k >= 50) num_errors++;
        @(negedge clk_sys) tx_valid = 0;
        k = 0;
        // rx_valid stands one cycle; look at it between edges
        while (rx_valid !== 1'b1 && k < 500) begin
            @(negedge clk_sys);
            k = k + 1;
        end
        if (k >= 500) num_errors++;
        `CHK(rx_word, sl_word)
        `CHK(got, tx_word)
        `CHK(nedge, 8)
        `CHK(oe, 1'b0)
    endtask
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h02FD));
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) reset = 0;
        for (c = 0; c < 4; c++) begin
            for (n = 0; n < 6; n++) begin
                xfer({1'b1, c[1]}, c[0], n < 5 ? n : $urandom % 8);
            end
        end
        @(negedge clk_sys) rcs = 1;
        tx_valid = 1;
        #1 `CHK(tx_ready, 1'b0)
        @(negedge clk_sys) rcs = 0;
        mode = 2'h1;
        #1 `CHK(tx_ready, 1'b0)
        @(negedge clk_sys) mode = 2'h3;
        tvs = 0;
        #1 `CHK(tx_ready, 1'b0)
        repeat (3) @(negedge clk_sys);
        `CHK(busy, 1'b0)
        tx_valid = 0;
        tvs = 1;
        report_and_stop;
    end
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
endmodule // test_serial_port_spi_master
